// ---- hdl/pwmc_consts.svh ----
// Register offsets, field positions and reset values of the width measurement channel
`ifndef PWMC_CONSTS_SVH
`define PWMC_CONSTS_SVH

// Register word offsets on the plain register port
`define PWMC_A_POWER 4'h0
`define PWMC_A_PRESCALE 4'h1
`define PWMC_A_NFILT 4'h2
`define PWMC_A_MODE 4'h3
`define PWMC_A_START 4'h4
`define PWMC_A_STOP 4'h5
`define PWMC_A_ENSTAT 4'h6
`define PWMC_A_CAPTURE 4'h7
`define PWMC_A_COUNTER 4'h8
`define PWMC_A_STATUS 4'h9
`define PWMC_A_OUTCTL 4'ha

// Mode register fields
`define PWMC_CKS_HI 15
`define PWMC_CKS_LO 14
`define PWMC_MSPLIT_BIT 11
`define PWMC_EDGE_HI 7
`define PWMC_EDGE_LO 6

// Output control fields
`define PWMC_OC_ENABLE 0
`define PWMC_OC_MODE 1
`define PWMC_OC_LEVEL 2
`define PWMC_OC_VALUE 3

// Edge select patterns and clock source codes
`define PWMC_EDGE_LOW_W 2'h2
`define PWMC_EDGE_HIGH_W 2'h3
`define PWMC_CKS_CK0 2'h0
`define PWMC_CKS_CK1 2'h2
`define PWMC_CKS_CK2 2'h1
`define PWMC_CKS_CK3 2'h3

// Reset values and counter limits
`define PWMC_WORD_RST 16'h0000
`define PWMC_CNT_MAX 16'hffff
`define PWMC_CNT_ONE 16'h0001

`endif

// ---- hdl/pwmc_pkg.sv ----
// Types shared by the width measurement channel
package pwmc_pkg;

    typedef enum logic [1:0] {
        PWMC_STOPPED = 2'b00,
        PWMC_WAIT = 2'b01,
        PWMC_COUNT = 2'b10
    } pwmc_phase_e;

    typedef struct packed {
        logic power;
        logic [15:0] prescale;
        logic nf_en;
        logic [15:0] mode;
        logic [3:0] outctl;
        logic enable;
        pwmc_phase_e phase;
        logic [15:0] cnt;
        logic [15:0] cap;
        logic ovf;
        logic ovf_int;
        logic [15:0] div;
        logic raw;
        logic filt;
        logic irq;
        logic tout;
        logic [15:0] rdata;
    } pwmc_state_s;

endpackage

// ---- hdl/pwmc_channel.sv ----
// Input high/low width measurement channel with its unit power, prescaler and noise filter
// Overview of operation
// - Width equals count period times 10000H*overflow plus capture plus one.
// - Capture input sampled on selected operation clock; one cycle uncertainty.
// - Counter counts up only between start edge and following capture edge.
// - Start trigger sets enable status and waits for start edge.
// - Start edge clears counter to 0000H, then counts each count clock.
// - Capture edge copies counter to capture value and pulses interrupt.
// - Each capture sets overflow flag if counter wrapped, else clears it.
// - After capture counter holds capture plus one; waits again, repeats.
// - Several wraps still only set overflow flag to one.
// - Edge select 10B measures low width, 11B measures high width.
// - Clock select 00B/10B pick clocks 0/1; 01B/11B clocks 2/3 on channels 1,3.
// - Mode bit: master on channels 2,4,6, split on 1,3, else zero.
// - Power bit zero stops clock, ignores writes; one starts with channel stopped.
// - Noise filter bit switches capture input filter off or on.
// - Prescaler select sets the four shared prescaled clock rates.
// - Stop trigger clears enable, halts counting, holds counter and overflow.
// - Start and stop triggers self clear and read back as zero.
// - Status always readable; mode and output writes ignored while running.
// - Clearing power bit initialises every circuit and channel register.
`include "pwmc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pwmc_channel #(
    parameter int CHANNEL = 1
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_timer_capture_input,
    output logic [15:0] o_rdata,
    output logic o_channel_interrupt,
    output logic o_channel_enable_status,
    output logic o_timer_output
);

    // Refuse channel numbers the unit does not have
    if (CHANNEL < 0 || CHANNEL > 7) begin : g_bad_channel
        $error("pwmc_channel: CHANNEL must be 0 to 7");
    end

    // Channel-dependent capabilities
    localparam logic WIDE_CLK = (CHANNEL == 1) || (CHANNEL == 3);
    localparam logic HAS_MSPLIT = (CHANNEL == 1) || (CHANNEL == 2) || (CHANNEL == 3) ||
                                  (CHANNEL == 4) || (CHANNEL == 6);

    pwmc_pkg::pwmc_state_s s_q;
    pwmc_pkg::pwmc_state_s s_d;
    logic [3:0] ck_tick;
    logic op_tick;
    logic [1:0] cks;
    logic [1:0] edge_sel;
    logic rise;
    logic fall;
    logic start_edge;
    logic cap_edge;
    logic wr_start;
    logic wr_stop;

    // Four shared prescaled clocks as enables: clock k divides by 2**prescale[4*k +: 4]
    for (genvar k = 0; k < 4; k++) begin : g_presc
        logic [15:0] mask;
        assign mask = 16'(16'h0001 << s_q.prescale[4*k +: 4]) - `PWMC_CNT_ONE;
        assign ck_tick[k] = s_q.power && ((s_q.div & mask) == `PWMC_WORD_RST);
    end

    // Operation clock pick; codes for clocks 2 and 3 fall back to clock 0 on narrow channels
    assign cks = s_q.mode[`PWMC_CKS_HI:`PWMC_CKS_LO];
    always_comb begin
        unique case (cks)
            `PWMC_CKS_CK0: op_tick = ck_tick[0];
            `PWMC_CKS_CK1: op_tick = ck_tick[1];
            `PWMC_CKS_CK2: op_tick = WIDE_CLK ? ck_tick[2] : ck_tick[0];
            `PWMC_CKS_CK3: op_tick = WIDE_CLK ? ck_tick[3] : ck_tick[0];
        endcase
    end

    assign edge_sel = s_q.mode[`PWMC_EDGE_HI:`PWMC_EDGE_LO];
    assign wr_start = i_wr && s_q.power && (i_addr == `PWMC_A_START) && i_wdata[0];
    assign wr_stop = i_wr && s_q.power && (i_addr == `PWMC_A_STOP) && i_wdata[0];

    // Whole channel next state
    always_comb begin
        s_d = s_q;
        s_d.irq = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        start_edge = 1'b0;
        cap_edge = 1'b0;

        // Prescaler base counter runs only while the unit clock is supplied
        if (s_q.power) begin
            s_d.div = s_q.div + `PWMC_CNT_ONE;
        end

        // Input sampled only on operation clock ticks, so edges carry one tick of jitter
        if (op_tick) begin
            s_d.raw = i_timer_capture_input;
            // Filter needs two equal samples in a row; costs one tick of latency
            if (!s_q.nf_en || (s_q.raw == i_timer_capture_input)) begin
                s_d.filt = i_timer_capture_input;
            end
            rise = s_d.filt && !s_q.filt;
            fall = !s_d.filt && s_q.filt;
        end

        // High width starts on rise and captures on fall; low width the other way
        if (edge_sel == `PWMC_EDGE_HIGH_W) begin
            start_edge = rise;
            cap_edge = fall;
        end else if (edge_sel == `PWMC_EDGE_LOW_W) begin
            start_edge = fall;
            cap_edge = rise;
        end

        // Measurement sequence
        unique case (s_q.phase)
            pwmc_pkg::PWMC_STOPPED: begin
            end
            pwmc_pkg::PWMC_WAIT: begin
                if (start_edge) begin
                    s_d.cnt = `PWMC_WORD_RST;
                    s_d.ovf_int = 1'b0;
                    s_d.phase = pwmc_pkg::PWMC_COUNT;
                end
            end
            pwmc_pkg::PWMC_COUNT: begin
                if (op_tick) begin
                    // Count runs on while the capture takes place, leaving capture plus one
                    s_d.cnt = s_q.cnt + `PWMC_CNT_ONE;
                    if (s_q.cnt == `PWMC_CNT_MAX) begin
                        s_d.ovf_int = 1'b1; // Sticky; repeated wraps look like one
                    end
                end
                if (cap_edge) begin
                    s_d.cap = s_q.cnt;
                    s_d.irq = 1'b1;
                    // Flag describes the value just captured, including a wrap on this tick
                    s_d.ovf = s_q.ovf_int || (s_q.cnt == `PWMC_CNT_MAX);
                    s_d.phase = pwmc_pkg::PWMC_WAIT;
                end
            end
            default: begin
                s_d.phase = pwmc_pkg::PWMC_STOPPED;
            end
        endcase

        // Triggers act for one cycle and leave nothing stored
        if (wr_start && !s_q.enable) begin
            // A start while enabled is ignored: only pin edges restart a measurement
            s_d.enable = 1'b1;
            s_d.phase = pwmc_pkg::PWMC_WAIT;
        end
        if (wr_stop) begin
            s_d.enable = 1'b0; // Counter and overflow flag keep their values
            s_d.phase = pwmc_pkg::PWMC_STOPPED;
            s_d.cnt = s_q.cnt;
            s_d.ovf = s_q.ovf;
        end

        // Configuration writes, all ignored while the unit is powered down
        if (i_wr && s_q.power) begin
            unique case (i_addr)
                `PWMC_A_PRESCALE: s_d.prescale = i_wdata;
                `PWMC_A_NFILT: s_d.nf_en = i_wdata[0];
                `PWMC_A_MODE: begin
                    // Mode is frozen while running so the sequence cannot be corrupted
                    if (!s_q.enable) begin
                        s_d.mode = i_wdata;
                        s_d.mode[`PWMC_MSPLIT_BIT] = HAS_MSPLIT & i_wdata[`PWMC_MSPLIT_BIT];
                    end
                end
                `PWMC_A_OUTCTL: begin
                    if (!s_q.enable) begin
                        s_d.outctl = i_wdata[3:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Output pin logic; stays low when software leaves the output disabled
        s_d.tout = s_q.outctl[`PWMC_OC_ENABLE] &
                   (s_q.outctl[`PWMC_OC_VALUE] ^ s_q.outctl[`PWMC_OC_LEVEL]);

        // Power bit itself is always writable; clearing it wipes the unit
        if (i_wr && (i_addr == `PWMC_A_POWER)) begin
            s_d.power = i_wdata[0];
        end
        if (!s_d.power) begin
            s_d = '0;
        end
        // Powering up leaves the channel stopped
        if (i_wr && (i_addr == `PWMC_A_POWER) && i_wdata[0] && !s_q.power) begin
            s_d.enable = 1'b0;
            s_d.phase = pwmc_pkg::PWMC_STOPPED;
        end

        // Read data stands for the single cycle after the strobe; status always readable
        s_d.rdata = `PWMC_WORD_RST;
        if (i_rd) begin
            unique case (i_addr)
                `PWMC_A_POWER: s_d.rdata = {15'h0000, s_q.power};
                `PWMC_A_PRESCALE: s_d.rdata = s_q.prescale;
                `PWMC_A_NFILT: s_d.rdata = {15'h0000, s_q.nf_en};
                `PWMC_A_MODE: s_d.rdata = s_q.mode;
                `PWMC_A_ENSTAT: s_d.rdata = {15'h0000, s_q.enable};
                `PWMC_A_CAPTURE: s_d.rdata = s_q.cap;
                `PWMC_A_COUNTER: s_d.rdata = s_q.cnt;
                `PWMC_A_STATUS: s_d.rdata = {15'h0000, s_q.ovf};
                `PWMC_A_OUTCTL: s_d.rdata = {12'h000, s_q.outctl};
                default: s_d.rdata = `PWMC_WORD_RST; // Triggers and holes read zero
            endcase
        end
    end

    // Single state register
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign o_rdata = s_q.rdata;
    assign o_channel_interrupt = s_q.irq;
    assign o_channel_enable_status = s_q.enable;
    assign o_timer_output = s_q.tout;

    // Checks of the measurement behaviour
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    chk_capture_copy: assert property (s_q.irq |-> s_q.cap == $past(s_q.cnt))
        else $error("capture value does not match counter at interrupt");
    chk_hold_plus_one: assert property (s_q.irq |-> (s_q.cnt == s_q.cap + `PWMC_CNT_ONE) &&
                                        (s_q.phase == pwmc_pkg::PWMC_WAIT))
        else $error("counter not capture plus one after capture");
    chk_start_enables: assert property ((wr_start && !s_q.enable) |=> s_q.enable &&
                                        (s_q.phase == pwmc_pkg::PWMC_WAIT))
        else $error("start trigger did not enable channel");
    chk_stop_holds: assert property (wr_stop |=> !s_q.enable && $stable(s_q.cnt) && $stable(s_q.ovf))
        else $error("stop trigger did not hold counter and flag");
    chk_start_from_zero: assert property (((s_q.phase == pwmc_pkg::PWMC_COUNT) &&
                                          ($past(s_q.phase) == pwmc_pkg::PWMC_WAIT)) |->
                                          s_q.cnt == `PWMC_WORD_RST)
        else $error("counter did not start from zero");
    chk_power_off_clear: assert property (!s_q.power |-> !s_q.enable && (s_q.cnt == `PWMC_WORD_RST) &&
                                          (s_q.cap == `PWMC_WORD_RST) && !s_q.ovf)
        else $error("powered down unit holds state");
    chk_trigger_reads_zero: assert property ((i_rd && (i_addr == `PWMC_A_START || i_addr == `PWMC_A_STOP))
                                             |=> o_rdata == `PWMC_WORD_RST)
        else $error("trigger register read non-zero");
    chk_count_on_tick: assert property (((s_q.phase == pwmc_pkg::PWMC_COUNT) && !op_tick) |=>
                                        $stable(s_q.cnt) || (s_q.phase != pwmc_pkg::PWMC_COUNT))
        else $error("counter moved without operation clock");
    chk_wrap_overflow: assert property (((s_q.phase == pwmc_pkg::PWMC_COUNT) && op_tick &&
                                        (s_q.cnt == `PWMC_CNT_MAX) && !cap_edge && !wr_stop) |=>
                                        s_q.ovf_int && (s_q.cnt == `PWMC_WORD_RST))
        else $error("counter wrap not noted");

    // Capture with no wrap anywhere in the window leaves the flag clear
    chk_ovf_clear: assert property (
        ((s_q.phase == pwmc_pkg::PWMC_COUNT) && cap_edge && !wr_stop && !s_q.ovf_int &&
         (s_q.cnt != `PWMC_CNT_MAX)) |=> !s_q.ovf)
        else $error("overflow flag not cleared at capture");

    // Any earlier wrap sets the flag, however many there were
    chk_ovf_set: assert property (
        ((s_q.phase == pwmc_pkg::PWMC_COUNT) && cap_edge && !wr_stop && s_q.ovf_int) |=>
        s_q.ovf || !s_q.power)
        else $error("overflow flag not set after wrap");

    // Mode writes are dropped while the unit has no clock
    chk_off_no_write: assert property (
        (!s_q.power && i_wr && (i_addr == `PWMC_A_MODE)) |=> (s_q.mode == `PWMC_WORD_RST))
        else $error("mode written while powered down");

    // A running channel keeps its mode, so the sequence cannot be bent
    chk_mode_frozen: assert property (
        (s_q.enable && i_wr && (i_addr == `PWMC_A_MODE)) |=> $stable(s_q.mode))
        else $error("mode changed while channel enabled");

    // Interrupt is a single-cycle pulse
    chk_irq_pulse: assert property (s_q.irq |=> !s_q.irq)
        else $error("interrupt longer than one cycle");

    // Interrupt only ever follows a counting cycle
    chk_irq_from_count: assert property (s_q.irq |-> ($past(s_q.phase) == pwmc_pkg::PWMC_COUNT))
        else $error("interrupt without a measurement");

    // Edge select decides which pin edge opens the window
    chk_start_edge: assert property (
        (((edge_sel == `PWMC_EDGE_HIGH_W) ? rise : ((edge_sel == `PWMC_EDGE_LOW_W) && fall)) &&
         (s_q.phase == pwmc_pkg::PWMC_WAIT) && !wr_stop) |=> (s_q.phase == pwmc_pkg::PWMC_COUNT) || !s_q.power)
        else $error("start edge did not open the window");

    // Filter ignores a sample that disagrees with the one before
    chk_filter_hold: assert property (
        (op_tick && s_q.nf_en && (s_q.raw != i_timer_capture_input)) |=> $stable(s_q.filt) || !s_q.power)
        else $error("filter passed a single odd sample");

    // Waiting counter keeps its value until the start edge (capture plus one after a capture)
    chk_wait_holds: assert property (
        ((s_q.phase == pwmc_pkg::PWMC_WAIT) && !start_edge) |=> $stable(s_q.cnt) || !s_q.power)
        else $error("counter moved while waiting");

    // Read data only stands in the cycle after a strobe
    chk_rdata_idle: assert property (!i_rd |=> (o_rdata == `PWMC_WORD_RST))
        else $error("read data without read strobe");

    // Enable status and sequencer agree at all times
    chk_enable_phase: assert property (
        s_q.enable == (s_q.phase != pwmc_pkg::PWMC_STOPPED))
        else $error("enable status out of step with sequencer");

    // A fresh window starts with no wrap noted
    chk_fresh_overflow: assert property (
        ((s_q.phase == pwmc_pkg::PWMC_COUNT) && ($past(s_q.phase) == pwmc_pkg::PWMC_WAIT)) |-> !s_q.ovf_int)
        else $error("stale wrap carried into new window");

    cov_capture: cover property (s_q.irq && !s_q.ovf);
    cov_capture_ovf: cover property (s_q.irq && s_q.ovf);
    cov_stop_counting: cover property ((s_q.phase == pwmc_pkg::PWMC_COUNT) ##1 !s_q.enable);
    cov_low_width: cover property (s_q.irq && (edge_sel == `PWMC_EDGE_LOW_W));

endmodule

`default_nettype wire

// ---- dv/pwmc_pin_model.sv ----
// Behavioural driver of the measured pin
`timescale 1ns/1ps
`default_nettype none

module pwmc_pin_model (
    input wire logic i_ref_clk,
    output var logic o_pin
);
    // Pin idles low until the bench parks it elsewhere
    initial o_pin = 1'b0;

    // Park the pin at a level, changed just after an edge
    task automatic idle(input logic lvl);
        @(posedge i_ref_clk);
        o_pin <= lvl;
    endtask

    // One pulse of w clocks; the pin always returns to the opposite level
    task automatic pulse(input logic lvl, input int w);
        @(posedge i_ref_clk);
        o_pin <= lvl;
        repeat (w) @(posedge i_ref_clk);
        o_pin <= ~lvl;
    endtask
endmodule

`default_nettype wire

// ---- dv/pulse_width_measurement_channel_tb_top.sv ----
// Self-checking bench for the width measurement channel
`timescale 1ns/1ps
`default_nettype none
`include "pwmc_consts.svh"

module pulse_width_measurement_channel_tb_top;
    typedef struct packed {
        logic [1:0] edge_sel;
        logic [1:0] cks;
        logic filt;
        logic [15:0] w;
        logic [15:0] cap;
    } pwmc_row_s;

    // Prescale 3210: ck0 every cycle, ck1 /2, ck2 /4, ck3 /8; widths are whole ticks
    localparam pwmc_row_s ROWS [6] = '{
        '{2'h3, 2'h0, 1'b0, 16'h0005, 16'h0004}, '{2'h2, 2'h0, 1'b0, 16'h0007, 16'h0006},
        '{2'h3, 2'h2, 1'b0, 16'h000a, 16'h0004}, '{2'h2, 2'h1, 1'b1, 16'h000c, 16'h0002},
        '{2'h3, 2'h3, 1'b1, 16'h0010, 16'h0001}, '{2'h3, 2'h0, 1'b0, 16'h0001, 16'h0000}};

    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic pin;
    logic [15:0] o_rdata;
    logic irq, en_stat, tout;
    int bad_count = 0;
    int n_checks = 0;
    int irq_cnt = 0;
    int base0;
    logic [15:0] c1;

    // Clock at 100 MHz
    initial forever #5 i_ref_clk = ~i_ref_clk;

    // Interrupt cycles counted, so a stretched pulse shows up
    always @(posedge i_ref_clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

    pwmc_channel #(.CHANNEL(1)) uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_timer_capture_input(pin), .o_rdata(o_rdata),
        .o_channel_interrupt(irq), .o_channel_enable_status(en_stat), .o_timer_output(tout));
    pwmc_pin_model pin_m (.i_ref_clk(i_ref_clk), .o_pin(pin));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    // Bus cycles start one edge after the call, so strobes never toggle twice in a step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] got;
        rd(a, got);
        chk(what, exp, got);
    endtask

    // Bounded wait for a capture, then a window to catch a second pulse
    task automatic wait_irq(input int base, input int n);
        for (int k = 0; k < 80 && irq_cnt == base; k++) @(posedge i_ref_clk);
        repeat (8) @(posedge i_ref_clk);
        chk("irq count", 16'(n), 16'(irq_cnt - base));
    endtask

    task automatic meas(input logic [1:0] es, input logic [1:0] cks, input logic filt, input int w,
                        input logic [15:0] cap, input logic ovf);
        int base;
        logic act;
        act = es[0];
        wr(`PWMC_A_STOP, 16'h0001);
        wr(`PWMC_A_NFILT, {15'h0000, filt});
        wr(`PWMC_A_MODE, {cks, 6'h00, es, 6'h00});
        pin_m.idle(~act);
        repeat (40) @(posedge i_ref_clk);
        wr(`PWMC_A_START, 16'h0001);
        repeat (3) @(posedge i_ref_clk);
        chk("enable status", 16'h0001, {15'h0000, en_stat});
        base = irq_cnt;
        pin_m.pulse(act, w);
        wait_irq(base, 1);
        rchk("capture", `PWMC_A_CAPTURE, cap);
        rchk("overflow", `PWMC_A_STATUS, {15'h0000, ovf});
        rchk("counter", `PWMC_A_COUNTER, cap + 16'h0001);
    endtask

    // Main sequence; the long overflow run dominates at about 66000 cycles
    initial begin
        repeat (20) @(posedge i_ref_clk);
        chk("outputs in reset", 16'h0000, {13'h0000, irq, en_stat, tout});
        i_rst <= 1'b0;
        wr(`PWMC_A_MODE, 16'h0800);
        wr(`PWMC_A_POWER, 16'h0001);
        rchk("mode before power", `PWMC_A_MODE, 16'h0000);
        rchk("enable after power", `PWMC_A_ENSTAT, 16'h0000);
        rchk("unmapped", 4'hf, 16'h0000);
        wr(`PWMC_A_MODE, 16'h0800);
        rchk("split bit", `PWMC_A_MODE, 16'h0800);
        wr(`PWMC_A_PRESCALE, 16'h3210);
        wr(`PWMC_A_OUTCTL, 16'h0009);
        repeat (3) @(posedge i_ref_clk);
        chk("timer output", 16'h0001, {15'h0000, tout});
        wr(`PWMC_A_OUTCTL, 16'h0000);
        $display("test reset and power done");
        foreach (ROWS[i]) begin
            meas(ROWS[i].edge_sel, ROWS[i].cks, ROWS[i].filt, ROWS[i].w, ROWS[i].cap, 1'b0);
            $display("test row %0d done", i);
        end
        meas(2'h3, 2'h0, 1'b0, 65541, 16'h0004, 1'b1);
        base0 = irq_cnt;
        pin_m.pulse(1'b1, 3);
        wait_irq(base0, 1);
        rchk("repeat capture", `PWMC_A_CAPTURE, 16'h0002);
        rchk("overflow cleared", `PWMC_A_STATUS, 16'h0000);
        rchk("start reads zero", `PWMC_A_START, 16'h0000);
        wr(`PWMC_A_MODE, 16'h0800);
        rchk("mode frozen", `PWMC_A_MODE, 16'h00c0);
        $display("test overflow done");
        // Stop in mid-measurement: count must freeze and no capture follows
        pin_m.idle(1'b1);
        repeat (10) @(posedge i_ref_clk);
        wr(`PWMC_A_STOP, 16'h0001);
        base0 = irq_cnt;
        rd(`PWMC_A_COUNTER, c1);
        repeat (5) @(posedge i_ref_clk);
        rchk("counter held", `PWMC_A_COUNTER, c1);
        chk("stop clears enable", 16'h0000, {15'h0000, en_stat});
        rchk("stop reads zero", `PWMC_A_STOP, 16'h0000);
        pin_m.idle(1'b0);
        wait_irq(base0, 0);
        $display("test stop done");
        wr(`PWMC_A_POWER, 16'h0000);
        wr(`PWMC_A_POWER, 16'h0001);
        rchk("capture cleared", `PWMC_A_CAPTURE, 16'h0000);
        rchk("prescale cleared", `PWMC_A_PRESCALE, 16'h0000);
        $display("test power off done");
        end_of_test();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (95000) @(posedge i_ref_clk);
        bad_count++;
        end_of_test();
    end
endmodule

`default_nettype wire
